// ### pkg/sbp_pkg.sv
// Functional notes
// R1 - Selected read drives word; count enable advances.
// R2 - Output enable high floats bus, still counts.
// R3 - Selected write stores bus word; counts if enabled.
// R4 - Deselect floats bus; pointer still counts.
// R5 - Controller raises output enable before write.
// R6 - Write ends when select or direction high.
// R7 - Counting increments before the cycle's operation.
// R8 - No command mode during sequential accesses.
// R9 - Start jump loads preset start in one cycle.
// R10 - Direct load captures bus, pointer next cycle.
// R11 - Jumps high during load and following cycle.
// R12 - Load address on bits 12..0, rest high.
// R13 - Reset acts asynchronously.
// R14 - Reset defaults: pointer, flags, modes, bounds.
// R15 - Command indices 0..3 reach buffer bounds.
// R16 - Index 4 flow modes, 5 flags, 6/7 reserved.
// R17 - Chaining: flag on end, jump other start.
// R18 - Stop: flag, stop pointer, block writes.
// R19 - Linear flags and counts; mask hides flag.
// R20 - Flow bit 4 zero releases stopped pointer; here only with count enabled on the next edge.
// R21 - Equal ends: both flags, chain to buffer one.
// R22 - Status bits show reached ends; zero clears.
// R23 - Command reads drive unused upper bits high.
// R24 - Writing one leaves a status bit unchanged.
// R25 - Reserved indices: no-op, read all ones.
// R26 - Clearing status releases the end flag output.
package sbp_pkg;

	// ----------------------------------------------------------------
	// Widths and command indices.
	// ----------------------------------------------------------------
	localparam int              ADDR_W           = 13;
	localparam int              DATA_W           = 16;
	localparam logic [2:0]      IDX_START_ONE    = 3'h0;
	localparam logic [2:0]      IDX_END_ONE      = 3'h1;
	localparam logic [2:0]      IDX_START_TWO    = 3'h2;
	localparam logic [2:0]      IDX_END_TWO      = 3'h3;
	localparam logic [2:0]      IDX_FLOW         = 3'h4;
	localparam logic [2:0]      IDX_FLAG         = 3'h5;

	// ----------------------------------------------------------------
	// Reset values, flow modes and field positions.
	// ----------------------------------------------------------------
	localparam logic [12:0]     RST_START_ONE    = 13'h0000;
	localparam logic [12:0]     RST_END_ONE      = 13'h0fff;
	localparam logic [12:0]     RST_START_TWO    = 13'h1000;
	localparam logic [12:0]     RST_END_TWO      = 13'h1fff;
	localparam logic [12:0]     RST_POINTER      = 13'h0000;
	localparam logic [1:0]      MODE_CHAIN       = 2'h0;
	localparam logic [1:0]      MODE_STOP        = 2'h1;
	localparam logic [1:0]      MODE_LINEAR      = 2'h2;
	localparam logic [1:0]      MODE_MASK        = 2'h3;
	localparam int              FLOW_ONE_LSB     = 0;
	localparam int              FLOW_TWO_LSB     = 2;
	localparam int              FLOW_RELEASE_BIT = 4;
	localparam int              STAT_ONE_BIT     = 0;
	localparam int              STAT_TWO_BIT     = 1;
	localparam logic [15:0]     ALL_ONES         = 16'hffff;

	// Address fields read back with the three unused top bits high.
	function automatic logic [15:0] pad_word(input logic [12:0] v);
		return {3'h7, v};
	endfunction

endpackage

// ### rtl/sbp_mem.sv
`timescale 1ns/1ns
// Storage array for the sequential port; read is combinational so
// the top can register the word straight onto its output pins.
module sbp_mem #(
	parameter int AW = 13,
	parameter int DW = 16
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] store [2**AW];

	// Write on the edge; the array itself carries no reset.
	always_ff @(posedge clk) begin
		if (we) begin
			store[addr] <= wdata;
		end
	end

	assign rdata = store[addr];

endmodule

// ### rtl/sbp_cmd_regs.sv
`timescale 1ns/1ns
// Command-mode register set: buffer bounds, flow modes and flag status.
module sbp_cmd_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        cmd_en,
	input  wire logic        rd_wr,
	input  wire logic [2:0]  idx,
	input  wire logic [15:0] wdata,
	input  wire logic        set_one,
	input  wire logic        set_two,
	output logic      [12:0] start_one_ff,
	output logic      [12:0] end_one_ff,
	output logic      [12:0] start_two_ff,
	output logic      [12:0] end_two_ff,
	output logic      [1:0]  mode_one_ff,
	output logic      [1:0]  mode_two_ff,
	output logic      [1:0]  status_ff,
	output logic             rel_pulse_ff,
	output logic      [15:0] rdata
);

	logic wr;
	logic clr_one;
	logic clr_two;

	assign wr      = cmd_en && !rd_wr;
	assign clr_one = wr && (idx == sbp_pkg::IDX_FLAG) && !wdata[sbp_pkg::STAT_ONE_BIT]; // [R22]
	assign clr_two = wr && (idx == sbp_pkg::IDX_FLAG) && !wdata[sbp_pkg::STAT_TWO_BIT]; // [R22]

	// ----------------------------------------------------------------
	// Buffer bounds; upper data bits are ignored on write.
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_one_ff <= sbp_pkg::RST_START_ONE; // [R14]
			end_one_ff   <= sbp_pkg::RST_END_ONE; // [R14]
			start_two_ff <= sbp_pkg::RST_START_TWO; // [R14]
			end_two_ff   <= sbp_pkg::RST_END_TWO; // [R14]
		end else if (wr) begin
			case (idx) // [R15]
				sbp_pkg::IDX_START_ONE: start_one_ff <= wdata[12:0];
				sbp_pkg::IDX_END_ONE:   end_one_ff   <= wdata[12:0];
				sbp_pkg::IDX_START_TWO: start_two_ff <= wdata[12:0];
				sbp_pkg::IDX_END_TWO:   end_two_ff   <= wdata[12:0];
				default: ; // Flow, flag and reserved codes leave bounds alone. [R25]
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flow modes and the one-cycle release request.
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_one_ff  <= sbp_pkg::MODE_CHAIN; // [R14]
			mode_two_ff  <= sbp_pkg::MODE_CHAIN; // [R14]
			rel_pulse_ff <= 1'b0;
		end else begin
			if (wr && idx == sbp_pkg::IDX_FLOW) begin
				mode_one_ff <= wdata[sbp_pkg::FLOW_ONE_LSB +: 2]; // [R16]
				mode_two_ff <= wdata[sbp_pkg::FLOW_TWO_LSB +: 2]; // [R16]
			end
			rel_pulse_ff <= wr && idx == sbp_pkg::IDX_FLOW
				&& !wdata[sbp_pkg::FLOW_RELEASE_BIT]; // [R20]
		end
	end

	// Status bits: a set in the same cycle as a clear wins, so no end is lost.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= 2'h0; // [R14]
		end else begin
			status_ff[0] <= set_one || (status_ff[0] && !clr_one); // [R22] [R24]
			status_ff[1] <= set_two || (status_ff[1] && !clr_two); // [R22] [R24]
		end
	end

	// Read mux; unused upper bits and reserved codes read high.
	always_comb begin
		case (idx)
			sbp_pkg::IDX_START_ONE: rdata = sbp_pkg::pad_word(start_one_ff); // [R23]
			sbp_pkg::IDX_END_ONE:   rdata = sbp_pkg::pad_word(end_one_ff);
			sbp_pkg::IDX_START_TWO: rdata = sbp_pkg::pad_word(start_two_ff);
			sbp_pkg::IDX_END_TWO:   rdata = sbp_pkg::pad_word(end_two_ff);
			sbp_pkg::IDX_FLOW:      rdata = {12'hfff, mode_two_ff, mode_one_ff}; // [R23]
			sbp_pkg::IDX_FLAG:      rdata = {14'h3fff, status_ff}; // [R22] [R23]
			default:                rdata = sbp_pkg::ALL_ONES; // [R25]
		endcase
	end

endmodule

// ### rtl/sbp_top.sv
`timescale 1ns/1ns
// Sequential buffer port: pointer control, end flags and command mode.
module sbp_top (
	input  wire logic        MCLK,
	input  wire logic        NRST,
	input  wire logic        SEQ_SELECT_N,
	input  wire logic        SEQ_READ_WRITE,
	input  wire logic        SEQ_OUTPUT_ENABLE_N,
	input  wire logic        COUNT_ENABLE_N,
	input  wire logic        POINTER_LOAD_N,
	input  wire logic        START_JUMP_ONE_N,
	input  wire logic        START_JUMP_TWO_N,
	input  wire logic [15:0] SEQ_DATA_IN,
	output logic      [15:0] SEQ_DATA_OUT,
	output logic             SEQ_DATA_OE,
	output logic             END_FLAG_ONE_N,
	output logic             END_FLAG_TWO_N,
	input  wire logic        COMMAND_SELECT_N,
	input  wire logic [2:0]  COMMAND_INDEX,
	input  wire logic        RANDOM_READ_WRITE,
	input  wire logic [15:0] RANDOM_DATA_IN,
	output logic      [15:0] RANDOM_DATA_OUT,
	output logic             RANDOM_DATA_OE
);

	// ----------------------------------------------------------------
	// Declarations.
	// ----------------------------------------------------------------
	logic [12:0] ptr_ff;
	logic [12:0] nxt_ptr;
	logic [12:0] adv_ptr;
	logic [12:0] hold_ff;
	logic        load_pend_ff;
	logic        stopped_ff;
	logic        nxt_stopped;
	logic [12:0] start_one;
	logic [12:0] end_one;
	logic [12:0] start_two;
	logic [12:0] end_two;
	logic [1:0]  mode_one;
	logic [1:0]  mode_two;
	logic [1:0]  status;
	logic        rel_pulse;
	logic [15:0] cmd_rd;
	logic [15:0] mem_rd;
	logic        cnt;
	logic        jump_one;
	logic        jump_two;
	logic        hit_one;
	logic        hit_two;
	logic        chain_one;
	logic        chain_two;
	logic        stop_here;
	logic        moved;
	logic        set_one;
	logic        set_two;
	logic        mem_we;

	// ----------------------------------------------------------------
	// Command registers and storage.
	// ----------------------------------------------------------------
	sbp_cmd_regs u_regs (
		.clk          (MCLK),
		.rst_n        (NRST),
		.cmd_en       (!COMMAND_SELECT_N),
		.rd_wr        (RANDOM_READ_WRITE),
		.idx          (COMMAND_INDEX),
		.wdata        (RANDOM_DATA_IN),
		.set_one      (set_one),
		.set_two      (set_two),
		.start_one_ff (start_one),
		.end_one_ff   (end_one),
		.start_two_ff (start_two),
		.end_two_ff   (end_two),
		.mode_one_ff  (mode_one),
		.mode_two_ff  (mode_two),
		.status_ff    (status),
		.rel_pulse_ff (rel_pulse),
		.rdata        (cmd_rd)
	);

	sbp_mem #(
		.AW (sbp_pkg::ADDR_W),
		.DW (sbp_pkg::DATA_W)
	) u_mem (
		.clk   (MCLK),
		.we    (mem_we),
		.addr  (nxt_ptr),
		.wdata (SEQ_DATA_IN),
		.rdata (mem_rd)
	);

	// ----------------------------------------------------------------
	// Pointer decode.
	// ----------------------------------------------------------------
	// Strobes come from controller logic on MCLK, so they are used unsynchronised.
	assign cnt       = !COUNT_ENABLE_N;
	assign jump_one  = POINTER_LOAD_N && !START_JUMP_ONE_N && START_JUMP_TWO_N; // [R9]
	assign jump_two  = POINTER_LOAD_N && START_JUMP_ONE_N && !START_JUMP_TWO_N; // [R9]
	assign hit_one   = (ptr_ff == end_one);
	assign hit_two   = (ptr_ff == end_two);
	assign chain_one = hit_one && (mode_one == sbp_pkg::MODE_CHAIN);
	assign chain_two = hit_two && (mode_two == sbp_pkg::MODE_CHAIN);
	assign stop_here = (hit_one && mode_one == sbp_pkg::MODE_STOP)
		|| (hit_two && mode_two == sbp_pkg::MODE_STOP); // [R18]

	// Advance target; with equal ends buffer two's chain goes to buffer one.
	always_comb begin
		if (chain_two) begin
			adv_ptr = start_one; // [R17] [R21]
		end else if (chain_one) begin
			adv_ptr = start_two; // [R17]
		end else begin
			adv_ptr = ptr_ff + 13'h0001; // [R19]
		end
	end

	// Next pointer. Load and jump win over counting; a stopped pointer only
	// moves on a release when count is enabled on the very next edge.
	always_comb begin
		nxt_ptr     = ptr_ff;
		nxt_stopped = stopped_ff;
		if (load_pend_ff) begin
			nxt_ptr     = hold_ff; // [R10]
			nxt_stopped = 1'b0; // [R20]
		end else if (!POINTER_LOAD_N) begin
			nxt_ptr     = ptr_ff; // [R10]
		end else if (jump_one || jump_two) begin
			nxt_ptr     = jump_one ? start_one : start_two; // [R9]
			nxt_stopped = 1'b0; // [R20]
		end else if (stopped_ff) begin
			if (rel_pulse && cnt) begin
				nxt_ptr     = adv_ptr; // [R20]
				nxt_stopped = 1'b0;
			end
		end else if (cnt) begin
			nxt_ptr     = adv_ptr; // [R1] [R4] [R7]
			nxt_stopped = stop_here; // [R18]
		end else begin
			nxt_stopped = stop_here; // [R18]
		end
	end

	// End reached when the pointer moves onto an end address.
	assign moved   = (nxt_ptr != ptr_ff);
	assign set_one = moved && (nxt_ptr == end_one); // [R17] [R19] [R21]
	assign set_two = moved && (nxt_ptr == end_two); // [R17] [R19] [R21]

	// Writes only when selected, in write direction, and not stopped.
	assign mem_we = !SEQ_SELECT_N && !SEQ_READ_WRITE && !nxt_stopped; // [R3] [R6] [R18]

	// ----------------------------------------------------------------
	// Pointer state.
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ptr_ff     <= sbp_pkg::RST_POINTER; // [R13] [R14]
			stopped_ff <= 1'b0; // [R20]
		end else begin
			ptr_ff     <= nxt_ptr;
			stopped_ff <= nxt_stopped;
		end
	end

	// Two-step load: capture on the first edge, apply on the next.
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			load_pend_ff <= 1'b0;
			hold_ff      <= sbp_pkg::RST_POINTER;
		end else begin
			load_pend_ff <= !POINTER_LOAD_N && !load_pend_ff; // [R10]
			if (!POINTER_LOAD_N && !load_pend_ff) begin
				hold_ff <= SEQ_DATA_IN[12:0]; // [R10]
			end
		end
	end

	// ----------------------------------------------------------------
	// Output registers.
	// ----------------------------------------------------------------
	// Output enable is registered, so the bus turns a cycle after the strobe;
	// a controller must allow that cycle before driving write data.
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			SEQ_DATA_OE  <= 1'b0; // [R14]
			SEQ_DATA_OUT <= 16'h0000;
		end else begin
			SEQ_DATA_OE  <= !SEQ_SELECT_N && SEQ_READ_WRITE && !SEQ_OUTPUT_ENABLE_N; // [R1] [R2] [R4]
			SEQ_DATA_OUT <= mem_rd; // [R1]
		end
	end

	// Flags follow the status bits; mask mode keeps the pin high.
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			END_FLAG_ONE_N <= 1'b1; // [R14]
			END_FLAG_TWO_N <= 1'b1; // [R14]
		end else begin
			END_FLAG_ONE_N <= !(status[0] && mode_one != sbp_pkg::MODE_MASK); // [R19] [R26]
			END_FLAG_TWO_N <= !(status[1] && mode_two != sbp_pkg::MODE_MASK); // [R19] [R26]
		end
	end

	// Command reads answer one cycle after the access cycle.
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			RANDOM_DATA_OE  <= 1'b0;
			RANDOM_DATA_OUT <= sbp_pkg::ALL_ONES;
		end else begin
			RANDOM_DATA_OE  <= !COMMAND_SELECT_N && RANDOM_READ_WRITE; // [R15]
			RANDOM_DATA_OUT <= cmd_rd; // [R23]
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!NRST);

	sequence s_load_cap;
		!POINTER_LOAD_N && START_JUMP_ONE_N && START_JUMP_TWO_N && !load_pend_ff
		##1 POINTER_LOAD_N && START_JUMP_ONE_N && START_JUMP_TWO_N;
	endsequence

	sequence s_plain;
		POINTER_LOAD_N && START_JUMP_ONE_N && START_JUMP_TWO_N && !load_pend_ff
		&& !stopped_ff;
	endsequence

	a_read_drive_on: assert property ( // [R1]
		!SEQ_SELECT_N && SEQ_READ_WRITE && !SEQ_OUTPUT_ENABLE_N |=> SEQ_DATA_OE)
		else $error("Read cycle did not drive the bus.");

	a_bus_float: assert property ( // [R2] [R4]
		SEQ_SELECT_N || SEQ_OUTPUT_ENABLE_N || !SEQ_READ_WRITE |=> !SEQ_DATA_OE)
		else $error("Bus driven outside an enabled read.");

	a_hold_no_count: assert property ( // [R1]
		s_plain and COUNT_ENABLE_N |=> ptr_ff == $past(ptr_ff))
		else $error("Pointer moved without count enable.");

	a_count_advance: assert property ( // [R7]
		s_plain and !COUNT_ENABLE_N && !chain_one && !chain_two
		|=> ptr_ff == $past(ptr_ff) + 13'h0001)
		else $error("Pointer did not advance by one.");

	a_load_two_step: assert property ( // [R10]
		s_load_cap |=> ptr_ff == $past(SEQ_DATA_IN[12:0], 2))
		else $error("Direct load did not reach the pointer.");

	a_jump_one_load: assert property ( // [R9]
		jump_one && !load_pend_ff |=> ptr_ff == $past(start_one))
		else $error("Start jump one missed.");

	a_chain_jump: assert property ( // [R17]
		s_plain and !COUNT_ENABLE_N && chain_one && !chain_two
		|=> ptr_ff == $past(start_two))
		else $error("Chaining did not move to buffer two start.");

	a_write_gate: assert property ( // [R3] [R6]
		mem_we |-> !SEQ_SELECT_N && !SEQ_READ_WRITE)
		else $error("Write strobe without selected write.");

	a_stop_blocks_write: assert property ( // [R18]
		stopped_ff && !rel_pulse && POINTER_LOAD_N && START_JUMP_ONE_N
		&& START_JUMP_TWO_N && !load_pend_ff |-> !mem_we)
		else $error("Write while pointer stopped.");

	a_flag_assert: assert property ( // [R17]
		set_one && mode_one != sbp_pkg::MODE_MASK |=> ##1 !END_FLAG_ONE_N)
		else $error("End flag one not asserted.");

	a_mask_hides: assert property ( // [R19]
		mode_one == sbp_pkg::MODE_MASK [*2] |-> END_FLAG_ONE_N)
		else $error("Mask mode drove end flag one.");

	a_reserved_ones: assert property ( // [R25]
		!COMMAND_SELECT_N && RANDOM_READ_WRITE && COMMAND_INDEX[2:1] == 2'b11
		|=> RANDOM_DATA_OUT == sbp_pkg::ALL_ONES)
		else $error("Reserved read not all ones.");

endmodule

// ### test/sbp_seq_ctl.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bus controller on the clocked side of the buffer port.
// ----------------------------------------------------------------
module sbp_seq_ctl (
	input  wire logic        mclk,
	output logic             sel_n,
	output logic             rw,
	output logic             oe_n,
	output logic             cnt_n,
	output logic             load_n,
	output logic             jmp1_n,
	output logic             jmp2_n,
	output logic      [15:0] dout
);

	// Sets every line at once, so a transfer never leaves one stale.
	task automatic put(input logic s, r, o, c, l, j1, j2, input logic [15:0] d);
		sel_n = s;
		rw = r;
		oe_n = o;
		cnt_n = c;
		load_n = l;
		jmp1_n = j1;
		jmp2_n = j2;
		dout = d;
	endtask

	// Lines change on the falling edge, so the rising edge sees them settled.
	task automatic drive(input logic s, r, o, c, l, j1, j2, input logic [15:0] d);
		@(negedge mclk);
		put(s, r, o, c, l, j1, j2, d);
	endtask

	// A released bus shows the inverse of its last word, never a stale copy.
	task automatic idle();
		drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ~dout);
	endtask

	// Writes always go out with output enable high, so data can be driven in.
	task automatic cycle(input logic s, r, o, c, input logic [15:0] d);
		drive(s, r, r ? o : 1'b1, c, 1'b1, 1'b1, 1'b1, (!s && !r) ? d : ~dout);
	endtask

	// Count enable is left low on purpose: the device must ignore it here.
	task automatic load(input logic [12:0] a);
		drive(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, {3'h7, a});
		drive(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, ~dout);
	endtask

	// One cycle with exactly one start line low.
	task automatic jump(input logic j1, j2);
		drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, j1, j2, ~dout);
	endtask

	// Idle levels from time zero.
	initial begin
		put(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
	end

endmodule

// ### test/tb_sequential_buffer_pointer_control.sv
`timescale 1ns/1ns
module tb_sequential_buffer_pointer_control;

	// ----------------------------------------------------------------
	// Signals.
	// ----------------------------------------------------------------
	logic        mclk;
	logic        nrst;
	logic        cmd_sel_n;
	logic [2:0]  cmd_idx;
	logic        cmd_rw;
	logic [15:0] cmd_wd;
	logic        sel_n, rw, oe_n, cnt_n, load_n, jmp1_n, jmp2_n;
	logic [15:0] seq_in;
	logic [15:0] seq_out;
	logic        seq_oe;
	logic        flag1_n;
	logic        flag2_n;
	logic [15:0] rnd_out;
	logic        rnd_oe;
	int          n_errors;
	int          n_checks;
	int          cycles;
	logic [15:0] rst_tab [8] = '{16'he000, 16'hefff, 16'hf000, 16'hffff,
	                             16'hfff0, 16'hfffc, 16'hffff, 16'hffff};

	// ----------------------------------------------------------------
	// Device and controller.
	// ----------------------------------------------------------------
	sbp_top uut (
		.MCLK(mclk), .NRST(nrst), .SEQ_SELECT_N(sel_n), .SEQ_READ_WRITE(rw),
		.SEQ_OUTPUT_ENABLE_N(oe_n), .COUNT_ENABLE_N(cnt_n), .POINTER_LOAD_N(load_n),
		.START_JUMP_ONE_N(jmp1_n), .START_JUMP_TWO_N(jmp2_n), .SEQ_DATA_IN(seq_in),
		.SEQ_DATA_OUT(seq_out), .SEQ_DATA_OE(seq_oe), .END_FLAG_ONE_N(flag1_n),
		.END_FLAG_TWO_N(flag2_n), .COMMAND_SELECT_N(cmd_sel_n), .COMMAND_INDEX(cmd_idx),
		.RANDOM_READ_WRITE(cmd_rw), .RANDOM_DATA_IN(cmd_wd), .RANDOM_DATA_OUT(rnd_out),
		.RANDOM_DATA_OE(rnd_oe)
	);

	sbp_seq_ctl ctl (
		.mclk(mclk), .sel_n(sel_n), .rw(rw), .oe_n(oe_n), .cnt_n(cnt_n),
		.load_n(load_n), .jmp1_n(jmp1_n), .jmp2_n(jmp2_n), .dout(seq_in)
	);

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	// Tagged word pattern, so a word read from the wrong place shows up.
	function automatic logic [15:0] dv(input logic [12:0] a);
		return {3'h5, a};
	endfunction

	task automatic chk(input logic [15:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic flg(input logic [15:0] e);
		chk({14'h0, flag2_n, flag1_n}, e);
	endtask

	// Read cycle, then look at the registered word one edge later.
	task automatic rd(input logic c, o, input logic [15:0] e);
		ctl.cycle(1'b0, 1'b1, o, c, 16'h0000);
		ctl.idle();
		chk({15'h0, seq_oe}, {15'h0, !o});
		if (!o) begin
			chk(seq_out, e);
		end
	endtask

	// Command access; the sequential lines keep whatever the controller last drove.
	task automatic cmd(input logic [2:0] i, input logic r, input logic [15:0] d, e);
		@(negedge mclk);
		cmd_sel_n = 1'b0;
		cmd_idx = i;
		cmd_rw = r;
		cmd_wd = d;
		@(negedge mclk);
		cmd_sel_n = 1'b1;
		cmd_wd = ~d;
		if (r) begin
			chk({15'h0, rnd_oe}, 16'h0001);
			chk(rnd_out, e);
		end
	endtask

	task automatic end_sim();
		if (n_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock and hang guard.
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
	end

	always #50 mclk = ~mclk;

	// The whole run needs well under a thousand cycles.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		cmd_sel_n = 1'b1;
		cmd_idx = 3'h0;
		cmd_rw = 1'b1;
		cmd_wd = 16'h0000;
		n_errors = 0;
		n_checks = 0;
		cycles = 0;
		repeat (10) @(negedge mclk);
		nrst = 1'b1;
		flg(16'h0003);
		cmd(3'h6, 1'b0, 16'h0000, 16'h0000);
		cmd(3'h7, 1'b0, 16'h0000, 16'h0000);
		for (int i = 0; i < 8; i++) cmd(3'(i), 1'b1, 16'h0000, rst_tab[i]);
		ctl.cycle(1'b0, 1'b0, 1'b1, 1'b1, dv(13'h0000));
		rd(1'b1, 1'b0, dv(13'h0000));
		// Fill 0x10..0x13 and 0x20; counted writes land one word further on.
		ctl.load(13'h0010);
		ctl.cycle(1'b0, 1'b0, 1'b1, 1'b1, dv(13'h0010));
		for (int i = 1; i < 4; i++) ctl.cycle(1'b0, 1'b0, 1'b1, 1'b0, dv(13'(16 + i)));
		ctl.load(13'h0020);
		ctl.cycle(1'b0, 1'b0, 1'b1, 1'b1, dv(13'h0020));
		ctl.load(13'h0010);
		rd(1'b1, 1'b0, dv(13'h0010));
		rd(1'b0, 1'b0, dv(13'h0011));
		rd(1'b0, 1'b1, 16'h0000);
		ctl.cycle(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
		ctl.idle();
		chk({15'h0, seq_oe}, 16'h0000);
		rd(1'b1, 1'b0, dv(13'h0013));
		// Buffer bounds: one is 0x10..0x11, two starts at 0x20.
		cmd(3'h0, 1'b0, 16'h0010, 16'h0000);
		cmd(3'h1, 1'b0, 16'h0011, 16'h0000);
		cmd(3'h2, 1'b0, 16'h0020, 16'h0000);
		cmd(3'h1, 1'b1, 16'h0000, 16'he011);
		ctl.jump(1'b1, 1'b0);
		rd(1'b1, 1'b0, dv(13'h0020));
		ctl.jump(1'b0, 1'b1);
		rd(1'b1, 1'b0, dv(13'h0010));
		rd(1'b0, 1'b0, dv(13'h0011));
		rd(1'b0, 1'b0, dv(13'h0020));
		flg(16'h0002);
		cmd(3'h5, 1'b1, 16'h0000, 16'hfffd);
		cmd(3'h5, 1'b0, 16'hfffe, 16'h0000);
		cmd(3'h5, 1'b1, 16'h0000, 16'hfffc);
		flg(16'h0003);
		// Stop mode: pointer parks at end+1 and writes are refused.
		cmd(3'h4, 1'b0, 16'hfff1, 16'h0000);
		cmd(3'h4, 1'b1, 16'h0000, 16'hfff1);
		ctl.jump(1'b0, 1'b1);
		ctl.cycle(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
		ctl.cycle(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
		rd(1'b0, 1'b0, dv(13'h0012));
		ctl.cycle(1'b0, 1'b0, 1'b1, 1'b0, 16'h5555);
		rd(1'b0, 1'b0, dv(13'h0012));
		flg(16'h0002);
		// Release by flow bit 4. Count enable stays low across the write because
		// the release needs it; the port is deselected and parked, so nothing moves early.
		ctl.cycle(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
		cmd(3'h4, 1'b0, 16'hffe1, 16'h0000);
		ctl.idle();
		rd(1'b1, 1'b0, dv(13'h0013));
		// A pointer parks on its end when the edge after the end does not count.
		ctl.jump(1'b0, 1'b1);
		rd(1'b0, 1'b0, dv(13'h0011));
		rd(1'b0, 1'b0, dv(13'h0011));
		ctl.jump(1'b0, 1'b1);
		rd(1'b1, 1'b0, dv(13'h0010));
		rd(1'b0, 1'b0, dv(13'h0011));
		// Linear shows the flag, mask hides it; both keep counting.
		for (int i = 2; i < 4; i++) begin
			cmd(3'h5, 1'b0, 16'hfffc, 16'h0000);
			cmd(3'h4, 1'b0, 16'hfff0 | 16'(i), 16'h0000);
			ctl.jump(1'b0, 1'b1);
			rd(1'b0, 1'b0, dv(13'h0011));
			rd(1'b0, 1'b0, dv(13'h0012));
			flg(i == 2 ? 16'h0002 : 16'h0003);
			cmd(3'h5, 1'b1, 16'h0000, 16'hfffd);
		end
		// Equal end addresses: both flags, chain back to buffer one.
		cmd(3'h5, 1'b0, 16'hfffc, 16'h0000);
		cmd(3'h4, 1'b0, 16'hfff0, 16'h0000);
		cmd(3'h3, 1'b0, 16'h0011, 16'h0000);
		ctl.jump(1'b0, 1'b1);
		rd(1'b0, 1'b0, dv(13'h0011));
		rd(1'b0, 1'b0, dv(13'h0010));
		flg(16'h0000);
		cmd(3'h5, 1'b1, 16'h0000, 16'hffff);
		cmd(3'h5, 1'b0, 16'hfffd, 16'h0000);
		cmd(3'h5, 1'b1, 16'h0000, 16'hfffd);
		flg(16'h0002);
		// Reset between edges must act at once.
		@(negedge mclk);
		#10 nrst = 1'b0;
		#10 flg(16'h0003);
		repeat (10) @(negedge mclk);
		nrst = 1'b1;
		cmd(3'h3, 1'b1, 16'h0000, 16'hffff);
		cmd(3'h4, 1'b1, 16'h0000, 16'hfff0);
		end_sim();
	end

endmodule
